// ---- src/tag_pkg.sv ----
// Purpose: Shared constants and types for the acquisition gating block
// Assumes: 40 MHz clk_sys, 12-bit converter codes
// Notes: Register indices map to byte address index * 4
package tag_pkg;
  localparam int DW = 12;
  localparam int AW = 7;
  localparam int IW = 5;
  localparam int CLK_NS = 25;
  // Register indices
  localparam logic [IW-1:0] IDX_CTRL1 = 5'h01;
  localparam logic [IW-1:0] IDX_CTRL2 = 5'h02;
  localparam logic [IW-1:0] IDX_LIM = 5'h04;
  localparam logic [IW-1:0] IDX_STAT = 5'h0C;
  localparam logic [IW-1:0] IDX_MASK = 5'h0D;
  localparam logic [IW-1:0] IDX_RES = 5'h10;
  localparam int NRES = 11;
  localparam int NLIM = 8;
  // Control field positions
  localparam int C1_SER = 11;
  localparam int C1_CH_HI = 10;
  localparam int C1_CH_LO = 7;
  localparam int C1_MD_HI = 1;
  localparam int C1_MD_LO = 0;
  localparam int C2_ACQ_HI = 9;
  localparam int C2_ACQ_LO = 8;
  localparam int C2_FCD_HI = 5;
  localparam int C2_FCD_LO = 4;
  localparam int C2_POL = 3;
  localparam logic [DW-1:0] CTRL_RST = 12'h000;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ONE = 2'h1;
  // Channel codes
  localparam logic [3:0] CH_XPOS = 4'h0;
  localparam logic [3:0] CH_YPOS = 4'h1;
  localparam logic [3:0] CH_Z2 = 4'h2;
  localparam logic [3:0] CH_AUX1 = 4'h3;
  localparam logic [3:0] CH_BAT1 = 4'h6;
  localparam logic [3:0] CH_BAT2 = 4'h7;
  localparam logic [3:0] CH_T1 = 4'h8;
  localparam logic [3:0] CH_T2 = 4'h9;
  localparam logic [3:0] CH_Z1 = 4'hA;
  // Timing, base figures scaled by 1, 2, 4, 8
  localparam int ACQ_NS = 400;
  localparam int FCD_NS = 1000;
  localparam int CW = 9;
  localparam logic [CW-1:0] ACQ_CYC = CW'((ACQ_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CW-1:0] FCD_CYC = CW'((FCD_NS + CLK_NS - 1) / CLK_NS);
  // Status bits
  localparam int SW = 5;
  localparam int ST_DONE = 0;
  localparam int ST_ALRT = 1;
  typedef struct packed {
    logic xp;
    logic xn;
    logic yp;
    logic yn;
  } tag_plate_t;
  typedef struct packed {
    logic [3:0] mux;
    logic ratio;
    logic bias_multi;
    logic track;
    logic start;
  } tag_adc_t;
  typedef enum logic [4:0] {
    S_IDLE = 5'b0_0001,
    S_FCD = 5'b0_0010,
    S_ACQ = 5'b0_0100,
    S_CONV = 5'b0_1000,
    S_STORE = 5'b1_0000
  } tag_state_t;
endpackage

// ---- src/tag_acq_gate.sv ----
// Purpose: Acquisition gating, channel switching and result storage
// Assumes: Avalon-MM slave, converter core on clk_sys
// Notes: Answers every access two edges after the request
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
module tag_acq_gate (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [tag_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic acquisition_halt_input,
  input wire logic conv_done,
  input wire logic [tag_pkg::DW-1:0] conv_code,
  output tag_pkg::tag_plate_t plate,
  output tag_pkg::tag_adc_t adc,
  output logic irq
);
  import tag_pkg::*;

  logic [DW-1:0] ctrl1_r;
  logic [DW-1:0] ctrl2_r;
  logic [DW-1:0] lim_r [NLIM];
  logic [DW-1:0] res_r [NRES];
  logic [SW-1:0] stat_r;
  logic [SW-1:0] mask_r;
  logic [SW-1:0] stat_nxt;
  logic halt_s1_r;
  logic halt_s2_r;
  logic run_r;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [DW-1:0] code_r;
  tag_state_t state_r;
  tag_state_t state_nxt;
  logic wait_r;
  logic [31:0] rdata_r;
  tag_plate_t plate_r;
  tag_plate_t plate_nxt;
  tag_adc_t adc_r;
  tag_adc_t adc_nxt;
  logic irq_r;

  // Decode
  wire [IW-1:0] idx = avs_address[AW-1:2];
  wire req = avs_read | avs_write;
  wire wr_go = avs_write & ~wait_r;
  wire wr_c1 = wr_go & (idx == IDX_CTRL1);
  wire wr_c2 = wr_go & (idx == IDX_CTRL2);
  wire wr_st = wr_go & (idx == IDX_STAT);
  wire wr_mk = wr_go & (idx == IDX_MASK);
  wire [DW-1:0] wdata = avs_writedata[DW-1:0];
  wire [1:0] wmode = wdata[C1_MD_HI:C1_MD_LO];
  wire [3:0] chan = ctrl1_r[C1_CH_HI:C1_CH_LO];
  wire [1:0] mode = ctrl1_r[C1_MD_HI:C1_MD_LO];
  wire halt_polarity_select = ctrl2_r[C2_POL];
  wire [1:0] acq_sel = ctrl2_r[C2_ACQ_HI:C2_ACQ_LO];
  wire [1:0] fcd_sel = ctrl2_r[C2_FCD_HI:C2_FCD_LO];
  wire [CW-1:0] acq_load = CW'((ACQ_CYC << acq_sel) - 1'b1);
  wire [CW-1:0] fcd_load = CW'((FCD_CYC << fcd_sel) - 1'b1);
  wire cnt_zero = (cnt_r == '0);

  // Halt level per polarity, every channel alike
  wire halt_act = halt_polarity_select ? halt_s2_r : ~halt_s2_r;

  // Result slot is the channel code
  wire [3:0] res_idx = chan;
  wire res_ok = (chan < 4'(NRES));

  // Limit pair for checked channels, single-bias diode only
  wire lim_hit = (chan == CH_AUX1) | (chan == CH_BAT1) |
    (chan == CH_BAT2) | (chan == CH_T1);
  wire [1:0] lim_k = (chan == CH_AUX1) ? 2'd0 :
    (chan == CH_BAT1) ? 2'd1 :
    (chan == CH_BAT2) ? 2'd2 : 2'd3;
  wire [DW-1:0] lim_hi = lim_r[{lim_k, 1'b0}];
  wire [DW-1:0] lim_lo = lim_r[{lim_k, 1'b1}];
  wire out_lim = lim_hit & ((code_r > lim_hi) | (code_r < lim_lo));
  wire stored = (state_r == S_STORE);

  // Sticky events, set wins over clear
  logic [SW-1:0] ev;
  always_comb begin
    ev = '0;
    ev[ST_DONE] = stored;
    ev[ST_ALRT + 32'(lim_k)] = stored & out_lim;
  end
  wire [SW-1:0] clr = wr_st ? wdata[SW-1:0] : '0;
  assign stat_nxt = (stat_r & ~clr) | ev;
  wire [SW-1:0] mask_nxt = wr_mk ? wdata[SW-1:0] : mask_r;

  // Read mux
  wire [IW-1:0] ridx = idx - IDX_RES;
  wire [IW-1:0] lidx = idx - IDX_LIM;
  wire in_res = (idx >= IDX_RES) & (ridx < IW'(NRES));
  wire in_lim = (idx >= IDX_LIM) & (lidx < IW'(NLIM));
  wire [DW-1:0] rd_val =
    (idx == IDX_CTRL1) ? ctrl1_r :
    (idx == IDX_CTRL2) ? ctrl2_r :
    (idx == IDX_STAT) ? DW'(stat_r) :
    (idx == IDX_MASK) ? DW'(mask_r) :
    in_lim ? lim_r[lidx[2:0]] :
    in_res ? res_r[ridx[3:0]] : '0;

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      S_IDLE: begin
        if (run_r) begin
          state_nxt = S_FCD;
          cnt_nxt = fcd_load;
        end
      end
      S_FCD: begin
        // Halt has no say during the delay
        if (!run_r) begin
          state_nxt = S_IDLE;
        end else if (cnt_zero) begin
          state_nxt = S_ACQ;
          cnt_nxt = acq_load;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      S_ACQ: begin
        if (!run_r) begin
          state_nxt = S_IDLE;
        end else if (halt_act) begin
          cnt_nxt = acq_load;
        end else if (cnt_zero) begin
          state_nxt = S_CONV;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      S_CONV: begin
        if (conv_done) begin
          state_nxt = S_STORE;
        end
      end
      S_STORE: begin
        state_nxt = S_IDLE;
        if (run_r && mode != MODE_ONE) begin
          state_nxt = S_ACQ;
          cnt_nxt = acq_load;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // Plate switches per channel
  wire active = (state_nxt != S_IDLE);
  wire is_z = (chan == CH_Z1) | (chan == CH_Z2);
  always_comb begin
    plate_nxt = '0;
    if (active) begin
      if (is_z) begin
        plate_nxt.yp = 1'b1;
        plate_nxt.xn = 1'b1;
      end else if (chan == CH_XPOS) begin
        plate_nxt.xp = 1'b1;
        plate_nxt.xn = 1'b1;
      end else if (chan == CH_YPOS) begin
        plate_nxt.yp = 1'b1;
        plate_nxt.yn = 1'b1;
      end
    end
  end

  // Converter front-end controls
  always_comb begin
    adc_nxt.mux = chan;
    adc_nxt.ratio = ~ctrl1_r[C1_SER];
    adc_nxt.bias_multi = (chan == CH_T2);
    adc_nxt.track = (state_nxt == S_ACQ) & ~halt_act;
    adc_nxt.start = (state_r == S_ACQ) & (state_nxt == S_CONV);
  end

  // Halt synchroniser
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      halt_s1_r <= 1'b0;
      halt_s2_r <= 1'b0;
    end else begin
      halt_s1_r <= acquisition_halt_input;
      halt_s2_r <= halt_s1_r;
    end
  end

  // Control registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl1_r <= CTRL_RST;
      ctrl2_r <= CTRL_RST;
      mask_r <= '0;
      stat_r <= '0;
    end else begin
      if (wr_c1) ctrl1_r <= wdata;
      if (wr_c2) ctrl2_r <= wdata;
      if (wr_mk) mask_r <= wdata[SW-1:0];
      stat_r <= stat_nxt;
    end
  end

  // Run control
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run_r <= 1'b0;
    end else if (wr_c1) begin
      run_r <= (wmode != MODE_OFF);
    end else if (stored && mode == MODE_ONE) begin
      run_r <= 1'b0;
    end
  end

  // Sequencer state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= S_IDLE;
      cnt_r <= '0;
      code_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (state_r == S_CONV && conv_done) code_r <= conv_code;
    end
  end

  // Limit and result registers
  genvar gi;
  generate
    for (gi = 0; gi < NLIM; gi++) begin : g_lim
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          lim_r[gi] <= '0;
        end else if (wr_go && idx == IDX_LIM + IW'(gi)) begin
          lim_r[gi] <= wdata;
        end
      end
    end
    for (gi = 0; gi < NRES; gi++) begin : g_res
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          res_r[gi] <= '0;
        end else if (stored && res_ok && res_idx == 4'(gi)) begin
          res_r[gi] <= code_r;
        end
      end
    end
  endgenerate

  // Bus answer and outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wait_r <= 1'b1;
      rdata_r <= '0;
      plate_r <= '0;
      adc_r <= '0;
      irq_r <= 1'b0;
    end else begin
      wait_r <= ~(req & wait_r);
      if (avs_read && wait_r) rdata_r <= 32'(rd_val);
      plate_r <= plate_nxt;
      adc_r <= adc_nxt;
      irq_r <= |(stat_nxt & mask_nxt);
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;
  assign plate = plate_r;
  assign adc = adc_r;
  assign irq = irq_r;

  // Checks
  default clocking chk_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  track_halt_a: assert property ((state_nxt == S_ACQ && halt_act)
    |=> !adc_r.track)
    else $error("tracking while halted");
  start_halt_a: assert property (adc_r.start |-> !$past(halt_act))
    else $error("conversion started under halt");
  abort_reload_a: assert property (
    (state_r == S_ACQ && run_r && halt_act) |=>
    (state_r == S_ACQ && cnt_r == $past(acq_load)))
    else $error("halt did not restart acquisition");
  pol_level_a: assert property (
    (wr_c2 && !wdata[C2_POL]) ##1 (halt_s2_r == 1'b0)[*2] |-> halt_act)
    else $error("low level not active with polarity zero");
  conv_hold_a: assert property (
    (state_r == S_CONV && !conv_done) |=> state_r == S_CONV)
    else $error("conversion left without done");
  z1_store_a: assert property (
    (stored && chan == CH_Z1) |=> res_r[CH_Z1] == $past(code_r))
    else $error("first pressure result not stored");
  z2_store_a: assert property (
    (stored && chan == CH_Z2) |=> res_r[CH_Z2] == $past(code_r))
    else $error("second pressure result not stored");
  z_plate_a: assert property (
    (state_r == S_ACQ && is_z) |-> (plate_r.yp && plate_r.xn &&
    !plate_r.xp && !plate_r.yn))
    else $error("pressure plates wrong");
  temp_lim_a: assert property (
    (stored && chan == CH_T2 && !wr_st) |=>
    stat_r[SW-1] == $past(stat_r[SW-1]))
    else $error("diode multi-bias result limit checked");
  rst_pol_a: assert property ($rose(rstn) |-> !halt_polarity_select)
    else $error("polarity not cleared by reset");
  irq_level_a: assert property (irq_r == |(stat_r & mask_r))
    else $error("interrupt level does not follow status");
  cov_restart_c: cover property (
    state_r == S_ACQ && halt_act ##1 !halt_act ##[1:200] adc_r.start);
  cov_z1_c: cover property (stored && chan == CH_Z1);
  cov_alert_c: cover property (stored && out_lim && chan == CH_T1);
  cov_pol_hi_c: cover property (halt_polarity_select && halt_act && state_r == S_ACQ);
endmodule // tag_acq_gate

// ---- dv/tag_conv_model.sv ----
// Purpose: Converter core stand-in that answers start pulses
// Assumes: One clock; start pulse and channel come in the adc struct
// Notes: Code is {channel, channel, 4'h5}; scrambled when not valid
module tag_conv_model
  import tag_pkg::*;
#(
  parameter int CONV_CYC = 12
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input tag_pkg::tag_adc_t adc,
  output logic conv_done,
  output logic [tag_pkg::DW-1:0] conv_code
);
  int cnt;
  logic [3:0] ch;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      ch <= 4'h0;
      conv_done <= 1'b0;
      conv_code <= 12'h000;
    end else begin
      conv_done <= (cnt == 1);
      conv_code <= (cnt == 1) ? {ch, ch, 4'h5} : ~conv_code;
      if (adc.start) begin
        ch <= adc.mux;
        cnt <= CONV_CYC;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // tag_conv_model

// ---- dv/tag_acq_gate_tb.sv ----
// Purpose: Self-checking bench for the acquisition gating block
// Assumes: 40 MHz clock, converter model on the far side
// Notes: Register access through Avalon-MM tasks only
module tag_acq_gate_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tag_pkg::*;
  logic clk_sys, rstn, avs_read, avs_write, halt_in, conv_done;
  logic avs_waitrequest, irq, bias_seen, ratio_seen;
  logic [AW-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [DW-1:0] conv_code;
  tag_plate_t plate, plate_seen;
  tag_adc_t adc;
  int bad_count, tests_run, n, m;
  logic [3:0] chs [6] = '{CH_Z1, CH_Z2, CH_T1, CH_T2, CH_BAT1, CH_BAT2};

  tag_acq_gate tag_acq_gate_i (.clk_sys(clk_sys), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .acquisition_halt_input(halt_in),
    .conv_done(conv_done), .conv_code(conv_code), .plate(plate),
    .adc(adc), .irq(irq));
  tag_conv_model tag_conv_model_i (.clk_sys(clk_sys), .rstn(rstn),
    .adc(adc), .conv_done(conv_done), .conv_code(conv_code));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (adc.track === 1'b1) begin
      plate_seen <= plate;
      bias_seen <= adc.bias_multi;
      ratio_seen <= adc.ratio;
    end
  end

  task automatic summarize();
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [IW-1:0] idx,
                     input logic [31:0] wd);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) bad_count++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic start(input logic [3:0] ch);
    bus(1'b1, IDX_CTRL1, {20'h0, 1'b1, ch, 1'b1, ch, MODE_ONE});
  endtask

  task automatic fin(input logic [3:0] ch, input logic [31:0] st);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (irq !== 1'b1 && n < 3000);
    if (n >= 3000) bad_count++;
    bus(1'b0, IDX_RES + {1'b0, ch}, 0);
    cmp(rd, {20'h0, ch, ch, 4'h5});
    bus(1'b0, IDX_STAT, 0);
    cmp(rd, st);
    bus(1'b1, IDX_STAT, 32'h0000_001F);
  endtask

  task automatic irq_is(input logic v);
    repeat (2) @(posedge clk_sys);
    cmp(irq, v);
  endtask

  initial begin
    rstn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    halt_in = 1'b1;
    plate_seen = '0;
    bias_seen = 1'b0;
    ratio_seen = 1'b1;
    bad_count = 0;
    tests_run = 0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, IDX_CTRL2, 0);
    cmp(rd, 0);
    bus(1'b1, IDX_CTRL1, 32'h0000_0D68);
    bus(1'b0, IDX_CTRL1, 0);
    cmp(rd, 32'h0000_0D68);
    bus(1'b1, 5'h1F, 32'h0000_0FFF);
    bus(1'b0, 5'h1F, 0);
    cmp(rd, 0);
    for (int k = 0; k < NLIM; k++) begin
      bus(1'b1, IDX_LIM + 5'(k), (k % 2) ? 32'h0 : 32'h0000_0FFF);
    end
    bus(1'b1, IDX_MASK, 32'h0000_0001);
    // Polarity 0 with pin low: acquisition held off
    halt_in <= 1'b0;
    start(CH_AUX1);
    m = 0;
    repeat (200) begin
      @(posedge clk_sys);
      m += (adc.track === 1'b1 || adc.start === 1'b1);
    end
    cmp(m, 0);
    halt_in <= 1'b1;
    fin(CH_AUX1, 32'h1);
    bus(1'b1, IDX_CTRL2, 32'h0000_0008);
    bus(1'b0, IDX_CTRL2, 0);
    cmp(rd, 32'h0000_0008);
    halt_in <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      start(chs[i]);
      fin(chs[i], 32'h1);
      if (i < 2) cmp(plate_seen, 4'b0110);
      if (i == 2) cmp(bias_seen, 1'b0);
      if (i == 3) cmp(bias_seen, 1'b1);
    end
    cmp(ratio_seen, 1'b0);
    // Halt in mid-acquisition, then during conversion
    start(CH_AUX1);
    m = 0;
    do begin
      @(posedge clk_sys);
      m++;
    end while (adc.track !== 1'b1 && m < 500);
    if (m >= 500) bad_count++;
    repeat (4) @(posedge clk_sys);
    halt_in <= 1'b1;
    m = 0;
    repeat (30) begin
      @(posedge clk_sys);
      m += (adc.start === 1'b1);
    end
    cmp(m, 0);
    cmp(adc.track, 1'b0);
    halt_in <= 1'b0;
    m = 0;
    do begin
      @(posedge clk_sys);
      m++;
    end while (adc.start !== 1'b1 && m < 100);
    cmp(m >= ACQ_CYC && m <= ACQ_CYC + 5, 1'b1);
    halt_in <= 1'b1;
    fin(CH_AUX1, 32'h1);
    halt_in <= 1'b0;
    // Diode limit alert, mask and clear
    bus(1'b1, IDX_LIM + 5'h06, 32'h0000_0800);
    bus(1'b1, IDX_MASK, 32'h0000_0011);
    start(CH_T1);
    fin(CH_T1, 32'h11);
    bus(1'b1, IDX_STAT, 32'h0000_0010);
    irq_is(1'b0);
    start(CH_T1);
    fin(CH_T1, 32'h11);
    bus(1'b1, IDX_RES + 5'h08, 32'h0000_0123);
    bus(1'b0, IDX_RES + 5'h08, 0);
    cmp(rd, 32'h0000_0885);
    bus(1'b1, IDX_CTRL2, 32'h0000_0000);
    bus(1'b0, IDX_CTRL2, 0);
    cmp(rd, 32'h0000_0000);
    summarize();
  end

  initial begin
    #(CLK_NS * 40000);
    bad_count++;
    summarize();
  end
endmodule // tag_acq_gate_tb
